// *** switch_reset_pkg.sv ***
// Purpose: shared constants for the switch reset propagation block
// Assumes: core clock of 50 MHz, one upstream port plus downstream ports
// Notes: times are kept in their own unit, cycle counts derive from them
`default_nettype none

package switch_reset_pkg;

	// core clock rate
	localparam int unsigned CLK_FREQ_KHZ = 50_000;

	// back-to-back training sets needed before a control bit is honoured
	localparam int unsigned OS_REPEAT_COUNT = 2;

	// length of an internally held hot reset, in microseconds
	localparam int unsigned HOT_RESET_HOLD_US = 2000;
	localparam int unsigned HOT_RESET_HOLD_CYCLES =
		(HOT_RESET_HOLD_US * CLK_FREQ_KHZ) / 1000;

	// default port count: downstream ports behind one upstream port
	localparam int unsigned DOWNSTREAM_PORTS = 11;

	// level of the synchronised board reset while the chip is in reset
	localparam logic BOARD_RESET_ASSERTED = 1'b0;

	// which in-band cause a detector watches
	typedef enum {
		CAUSE_HOT_RESET,
		CAUSE_LOOPBACK,
		CAUSE_DISABLE
	} os_cause_type;

endpackage

`default_nettype wire

// *** level_sync.sv ***
// Purpose: two flip-flop synchroniser for a level from outside the clock
// Assumes: the input changes slowly compared with the clock
// Notes: the first stage feeds only the second stage
`default_nettype none

module level_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// asynchronous level in, synchronised level out
	input wire logic async_i,
	output logic sync_o
);

	logic meta;

	// reset takes a constant; the caller picks the safe level
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			meta <= RESET_VALUE;
			sync_o <= RESET_VALUE;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end

endmodule

`default_nettype wire

// *** ordered_set_counter.sv ***
// Purpose: counts back-to-back training ordered sets carrying one control bit
// Assumes: one decoded ordered set per valid pulse, from core-clock logic
// Notes: sets outside the watched kinds (skip and the like) are ignored
`default_nettype none

module ordered_set_counter #(
	parameter int unsigned REPEAT = switch_reset_pkg::OS_REPEAT_COUNT
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// decoded ordered set
	input wire logic os_valid_i,
	input wire logic os_watched_i,
	input wire logic os_bit_set_i,
	// results
	output logic seen_o,
	output logic hit_o
);

	import switch_reset_pkg::*;

	localparam int unsigned CW = $clog2(REPEAT + 1);
	localparam logic [CW-1:0] TARGET = CW'(REPEAT);

	typedef struct packed {
		logic [CW-1:0] count;
		logic seen;
		logic hit;
	} cnt_state_type;

	cnt_state_type state;
	cnt_state_type next_state;

	generate
		if (REPEAT < 1) begin : g_bad_repeat
			$error("ordered_set_counter needs REPEAT of at least one");
		end
	endgenerate

	// count matching sets; any watched set lacking the bit starts over
	always_comb begin
		next_state = state;
		next_state.hit = 1'b0;
		if (os_valid_i && os_watched_i) begin
			if (!os_bit_set_i) begin
				next_state.count = '0;
				next_state.seen = 1'b0;
			end else if (state.count != TARGET) begin
				next_state.count = state.count + CW'(1);
				if (state.count + CW'(1) == TARGET) begin
					next_state.hit = 1'b1;
					next_state.seen = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign seen_o = state.seen;
	assign hit_o = state.hit;

endmodule

`default_nettype wire

// *** switch_reset_ctrl.sv ***
// Purpose: decides which reset level hits which port, and what it clears
// Assumes: link and bridge-control inputs come from core-clock logic;
//   only the board reset pin is asynchronous
// Notes: all reset outputs are active high levels unless named as pulses
`default_nettype none

// Summary of operation
// - board reset release reinitialises everything, reloads, re-evaluates
// - two back-to-back hot-reset TS1 start hot reset
// - unexpected upstream DL_Down starts hot reset
// - link down in L2 is not propagated
// - hot reset clears ports, non-sticky registers, reloads if a memory is fitted; clocks run
// - hot reset keeps port config and sticky fields
// - hot reset reinitialises every port's credits and queues
// - hot reset propagates to transparent downstream ports
// - secondary bus reset bit resets that bridge's hierarchy
// - upstream bus reset: transparent downstream ports send hot reset
// - upstream bus reset defaults downstream registers only, no reload
// - upstream bus reset: downstream links down, upstream stays up
// - downstream bus reset: port resets, registers kept
// - downstream bus reset: drain, reinit credits, drop requests
module switch_reset_ctrl
	import switch_reset_pkg::*;
#(
	parameter int unsigned NUM_DS = DOWNSTREAM_PORTS,
	parameter int unsigned HOT_HOLD_CYCLES = HOT_RESET_HOLD_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// board pin
	input wire logic board_fundamental_reset_n_i,
	// upstream physical layer: decoded training ordered sets
	input wire logic us_os_valid_i,
	input wire logic us_os_ts1_i,
	input wire logic us_os_ts2_i,
	input wire logic us_os_hot_reset_i,
	input wire logic us_os_loopback_i,
	input wire logic us_os_disable_i,
	// upstream link state
	input wire logic us_dl_up_i,
	input wire logic us_link_l2_i,
	// bridge control secondary bus reset bits
	input wire logic us_sec_bus_reset_i,
	input wire logic [NUM_DS-1:0] ds_sec_bus_reset_i,
	// configuration
	input wire logic [NUM_DS-1:0] ds_transparent_i,
	input wire logic cfg_mem_present_i,
	// whole-chip resets
	output logic core_reset_o,
	output logic port_cfg_reset_o,
	output logic sticky_reset_o,
	output logic nonsticky_reset_o,
	output logic hardware_initialised_field_eval_o,
	output logic cfg_load_start_o,
	// upstream port
	output logic us_phy_loopback_o,
	output logic us_phy_disabled_o,
	output logic us_tl_dl_up_o,
	output logic us_credit_init_o,
	// downstream ports
	output logic [NUM_DS-1:0] ds_hot_reset_tx_o,
	output logic [NUM_DS-1:0] ds_link_down_o,
	output logic [NUM_DS-1:0] ds_drop_requests_o,
	output logic [NUM_DS-1:0] ds_reg_default_o,
	output logic [NUM_DS-1:0] ds_credit_init_o
);

	localparam int unsigned HW = $clog2(HOT_HOLD_CYCLES + 1);
	localparam logic [HW-1:0] HOLD_LAST = HW'(HOT_HOLD_CYCLES - 1);

	typedef struct packed {
		logic board_q;
		logic core_rst;
		logic cfg_rst;
		logic sticky_rst;
		logic nonsticky_rst;
		logic hardware_initialised_field_eval;
		logic load_start;
		logic hot_active;
		logic hot_prop;
		logic [HW-1:0] hot_cnt;
		logic dl_up_q;
		logic loopback;
		logic disabled;
		logic us_tl_up;
		logic us_cred;
		logic [NUM_DS-1:0] ds_hot_tx;
		logic [NUM_DS-1:0] ds_down;
		logic [NUM_DS-1:0] ds_drop;
		logic [NUM_DS-1:0] ds_regdef;
		logic [NUM_DS-1:0] ds_cred;
	} ctrl_state_type;

	ctrl_state_type state;
	ctrl_state_type next_state;

	logic board_n_sync;
	logic os_ts_any;
	logic hot_hit;
	logic loop_seen;
	logic loop_hit;
	logic dis_seen;
	logic dis_hit;

	// elaboration checks on the port count and hold time
	generate
		if (NUM_DS < 1) begin : g_bad_ports
			$error("switch_reset_ctrl needs at least one downstream port");
		end
		if (HOT_HOLD_CYCLES < 1) begin : g_bad_hold
			$error("switch_reset_ctrl needs a hot reset hold of one cycle");
		end
	endgenerate

	// the board pin is the only asynchronous input
	level_sync #(
		.RESET_VALUE(BOARD_RESET_ASSERTED)
	) u_board_sync (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.async_i(board_fundamental_reset_n_i),
		.sync_o(board_n_sync)
	);

	assign os_ts_any = us_os_ts1_i | us_os_ts2_i;

	// hot reset counts TS1 only; TS2 sets leave that count alone
	ordered_set_counter #(
		.REPEAT(OS_REPEAT_COUNT)
	) u_hot_det (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.os_valid_i(us_os_valid_i),
		.os_watched_i(us_os_ts1_i),
		.os_bit_set_i(us_os_hot_reset_i),
		.seen_o(),
		.hit_o(hot_hit)
	);

	// loopback and disable accept TS1 or TS2
	ordered_set_counter #(
		.REPEAT(OS_REPEAT_COUNT)
	) u_loop_det (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.os_valid_i(us_os_valid_i),
		.os_watched_i(os_ts_any),
		.os_bit_set_i(us_os_loopback_i),
		.seen_o(loop_seen),
		.hit_o(loop_hit)
	);

	// a disable from upstream arrives as these sets
	ordered_set_counter #(
		.REPEAT(OS_REPEAT_COUNT)
	) u_dis_det (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.os_valid_i(us_os_valid_i),
		.os_watched_i(os_ts_any),
		.os_bit_set_i(us_os_disable_i),
		.seen_o(dis_seen),
		.hit_o(dis_hit)
	);

	// next state: fundamental reset first, then hot reset, then bus resets
	always_comb begin
		logic dl_drop;
		logic hot_start;
		logic board_rise;
		logic [NUM_DS-1:0] sbr_mask;
		dl_drop = 1'b0;
		hot_start = 1'b0;
		board_rise = 1'b0;
		sbr_mask = '0;
		next_state = state;
		next_state.board_q = board_n_sync;
		next_state.hardware_initialised_field_eval = 1'b0;
		next_state.load_start = 1'b0;
		next_state.dl_up_q = us_dl_up_i;
		board_rise = board_n_sync && !state.board_q;
		// unexpected fall of the upstream data link
		dl_drop = state.dl_up_q && !us_dl_up_i && !state.core_rst;
		hot_start = hot_hit || dl_drop || loop_hit || dis_hit;

		if (board_n_sync == BOARD_RESET_ASSERTED) begin
			// everything held, including sticky fields and clock logic
			next_state = '1;
			next_state.board_q = board_n_sync;
			next_state.hardware_initialised_field_eval = 1'b0;
			next_state.load_start = 1'b0;
			next_state.hot_active = 1'b0;
			next_state.hot_prop = 1'b0;
			next_state.hot_cnt = '0;
			next_state.dl_up_q = 1'b0;
			next_state.loopback = 1'b0;
			next_state.disabled = 1'b0;
			next_state.us_tl_up = 1'b0;
			next_state.ds_hot_tx = '0;
		end else begin
			if (state.core_rst) begin
				// release: loader always runs, hardware-set fields re-read
				next_state.core_rst = 1'b0;
				next_state.cfg_rst = 1'b0;
				next_state.sticky_rst = 1'b0;
				next_state.hardware_initialised_field_eval = board_rise || state.core_rst;
				next_state.load_start = 1'b1;
			end

			// loopback and disabled track the upstream training sets
			next_state.loopback = loop_seen;
			next_state.disabled = dis_seen;

			// hot reset: restart the hold on every new cause
			if (hot_start && !state.core_rst) begin
				next_state.hot_active = 1'b1;
				next_state.hot_cnt = '0;
				// a link lost while in L2 stays inside the switch
				if (!(dl_drop && us_link_l2_i) || hot_hit) begin
					next_state.hot_prop = 1'b1;
				end else if (!state.hot_active) begin
					next_state.hot_prop = 1'b0;
				end
			end else if (state.hot_active) begin
				if (state.hot_cnt == HOLD_LAST) begin
					next_state.hot_active = 1'b0;
					next_state.hot_prop = 1'b0;
					// restart the loader only if a memory is fitted
					next_state.load_start = cfg_mem_present_i;
				end else begin
					next_state.hot_cnt = state.hot_cnt + HW'(1);
				end
			end

			// clock logic, port config and sticky fields are not touched
			next_state.nonsticky_rst = next_state.hot_active;
			next_state.us_cred = next_state.hot_active;
			next_state.us_tl_up = us_dl_up_i && !next_state.hot_active;

			// per-port bus reset: upstream bit covers every port
			sbr_mask = ds_sec_bus_reset_i;
			if (us_sec_bus_reset_i) begin
				sbr_mask = '1;
			end

			// the non-transparent link never carries a hot reset
			next_state.ds_hot_tx = ds_transparent_i &
				(sbr_mask | {NUM_DS{next_state.hot_prop}});
			next_state.ds_down = sbr_mask |
				{NUM_DS{next_state.hot_active}};
			// requests to a port with its link down are dropped
			next_state.ds_drop = next_state.ds_down;
			// only hot reset and the upstream bit default downstream registers
			next_state.ds_regdef = {NUM_DS{next_state.hot_active}} |
				{NUM_DS{us_sec_bus_reset_i}};
			next_state.ds_cred = next_state.ds_down;
		end
	end

	// one register holds the whole state
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state <= '1;
			state.board_q <= 1'b0;
			state.hardware_initialised_field_eval <= 1'b0;
			state.load_start <= 1'b0;
			state.hot_active <= 1'b0;
			state.hot_prop <= 1'b0;
			state.hot_cnt <= '0;
			state.dl_up_q <= 1'b0;
			state.loopback <= 1'b0;
			state.disabled <= 1'b0;
			state.us_tl_up <= 1'b0;
			state.ds_hot_tx <= '0;
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from the state register
	assign core_reset_o = state.core_rst;
	assign port_cfg_reset_o = state.cfg_rst;
	assign sticky_reset_o = state.sticky_rst;
	assign nonsticky_reset_o = state.nonsticky_rst;
	assign hardware_initialised_field_eval_o = state.hardware_initialised_field_eval;
	assign cfg_load_start_o = state.load_start;
	assign us_phy_loopback_o = state.loopback;
	assign us_phy_disabled_o = state.disabled;
	assign us_tl_dl_up_o = state.us_tl_up;
	assign us_credit_init_o = state.us_cred;
	assign ds_hot_reset_tx_o = state.ds_hot_tx;
	assign ds_link_down_o = state.ds_down;
	assign ds_drop_requests_o = state.ds_drop;
	assign ds_reg_default_o = state.ds_regdef;
	assign ds_credit_init_o = state.ds_cred;

endmodule

`default_nettype wire

// *** upstream_model.sv ***
// Purpose: upstream link partner that sends decoded training sets
// Assumes: one decoded set per clock while a burst is sent
// Notes: bits are {ts1, ts2, hot reset, loopback, disable}
`default_nettype none

module upstream_model (
	// clock
	input wire logic ref_clk_i,
	// decoded ordered sets toward the switch
	output logic os_valid_o,
	output logic [4:0] os_bits_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// quiet link at time zero
	initial begin
		os_valid_o = 1'b0;
		os_bits_o = 5'h00;
	end

	// n back-to-back sets; a bus reset bit upstream gives hot sets
	// and a link disable bit upstream gives disable sets
	task automatic send(input int n, input logic [4:0] bits);
		repeat (n) begin
			@(posedge ref_clk_i);
			os_valid_o <= 1'b1;
			os_bits_o <= bits;
		end
		@(posedge ref_clk_i);
		os_valid_o <= 1'b0;
		// stale qualifiers flip so they cannot pass for a set
		os_bits_o <= ~bits;
	endtask
endmodule

`default_nettype wire

// *** switch_reset_sva.sv ***
// Purpose: port-level assertions for the reset propagation block
// Assumes: short hot reset hold of 8 cycles in simulation
// Notes: transparency inputs are held steady by the bench
`default_nettype none

module switch_reset_chk #(
	parameter int unsigned NUM_DS = 2,
	parameter int unsigned HOT_HOLD_CYCLES = 8
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// watched inputs
	input wire logic us_os_valid_i,
	input wire logic us_os_ts1_i,
	input wire logic us_os_ts2_i,
	input wire logic us_os_hot_reset_i,
	input wire logic us_os_loopback_i,
	input wire logic us_dl_up_i,
	input wire logic us_link_l2_i,
	input wire logic us_sec_bus_reset_i,
	input wire logic [NUM_DS-1:0] ds_sec_bus_reset_i,
	input wire logic [NUM_DS-1:0] ds_transparent_i,
	input wire logic cfg_mem_present_i,
	// watched outputs
	input wire logic core_reset_o,
	input wire logic port_cfg_reset_o,
	input wire logic sticky_reset_o,
	input wire logic nonsticky_reset_o,
	input wire logic hardware_initialised_field_eval_o,
	input wire logic cfg_load_start_o,
	input wire logic us_phy_loopback_o,
	input wire logic us_tl_dl_up_o,
	input wire logic us_credit_init_o,
	input wire logic [NUM_DS-1:0] ds_hot_reset_tx_o,
	input wire logic [NUM_DS-1:0] ds_link_down_o,
	input wire logic [NUM_DS-1:0] ds_drop_requests_o,
	input wire logic [NUM_DS-1:0] ds_reg_default_o,
	input wire logic [NUM_DS-1:0] ds_credit_init_o
);
	// qualifying sets; causes during fundamental reset are ignored
	wire hot_set = us_os_valid_i && us_os_ts1_i && us_os_hot_reset_i &&
		!core_reset_o;
	wire lb_set = us_os_valid_i && us_os_ts2_i && us_os_loopback_i &&
		!core_reset_o;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	a_release_pulses: assert property ($fell(core_reset_o) |->
		hardware_initialised_field_eval_o && cfg_load_start_o)
		else $error("no pulses at core reset release");
	a_hot_start: assert property (hot_set ##1 hot_set |->
		##[2:3] nonsticky_reset_o)
		else $error("two hot sets gave no hot reset");
	a_link_drop: assert property ($fell(us_dl_up_i) && !core_reset_o |->
		##[1:3] nonsticky_reset_o)
		else $error("link drop gave no hot reset");
	a_l2_quiet: assert property ($fell(us_dl_up_i) && us_link_l2_i |->
		##1 (ds_hot_reset_tx_o == '0)[*6])
		else $error("hot reset sent after drop in L2");
	a_loop_enter: assert property (lb_set ##1 lb_set |->
		##[1:3] us_phy_loopback_o)
		else $error("loopback not entered");
	a_hot_keeps: assert property (nonsticky_reset_o && !core_reset_o |->
		!sticky_reset_o && !port_cfg_reset_o)
		else $error("sticky or port config reset in hot reset");
	a_hot_clears: assert property ($rose(nonsticky_reset_o) |->
		us_credit_init_o && &ds_credit_init_o && &ds_link_down_o)
		else $error("credits not reset with hot reset");
	a_hold_len: assert property ($rose(nonsticky_reset_o) &&
		!core_reset_o |-> nonsticky_reset_o[*8])
		else $error("hot reset hold too short");
	a_hot_reload: assert property ($fell(nonsticky_reset_o) &&
		cfg_mem_present_i && !core_reset_o |-> ##[0:1] cfg_load_start_o)
		else $error("no reload after hot reset");
	a_tx_mask: assert property (
		(ds_hot_reset_tx_o & ~ds_transparent_i) == '0)
		else $error("hot reset sent on nontransparent port");
	a_us_bus: assert property (us_sec_bus_reset_i && !core_reset_o |=>
		&ds_reg_default_o && &ds_link_down_o && &ds_drop_requests_o)
		else $error("upstream bus reset missed a port");
	a_us_stays_up: assert property (us_sec_bus_reset_i && us_dl_up_i &&
		!nonsticky_reset_o && !core_reset_o |=> us_tl_dl_up_o)
		else $error("upstream link dropped in bus reset");
	a_ds_bus: assert property ($rose(ds_sec_bus_reset_i[0]) &&
		!us_sec_bus_reset_i && !nonsticky_reset_o && !core_reset_o |=>
		ds_link_down_o[0] && ds_credit_init_o[0] && !ds_reg_default_o[0])
		else $error("downstream bus reset wrong");
endmodule

bind switch_reset_ctrl switch_reset_chk #(
	.NUM_DS(NUM_DS),
	.HOT_HOLD_CYCLES(HOT_HOLD_CYCLES)
) chk (.*);

`default_nettype wire

// *** switch_reset_ctrl_tb.sv ***
// Purpose: self-checking bench for the reset propagation block
// Assumes: hold of 8 cycles, two ports, port 1 nontransparent
// Notes: fixed waits leave one or two spare cycles; hot reset ends are sampled on their exact cycle
`default_nettype none

module switch_reset_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, rst, pin_n, dl_up, l2, us_sbr, os_valid;
	logic core_rst, cfg_rst, sticky_rst, ns_rst, hardware_initialised_field, cfg_load;
	logic loop, dis, tl_up, us_cred, mem;
	logic [4:0] os_bits;
	logic [1:0] ds_sbr, hot_tx, down, drop, regdef, cred;
	int mismatches = 0;
	int comparisons = 0;

	// 50 MHz core clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	upstream_model up (.ref_clk_i(clk), .os_valid_o(os_valid),
		.os_bits_o(os_bits));

	switch_reset_ctrl #(.NUM_DS(2), .HOT_HOLD_CYCLES(8)) dut (
		.ref_clk_i(clk),
		.reset_i(rst),
		.board_fundamental_reset_n_i(pin_n),
		.us_os_valid_i(os_valid),
		.us_os_ts1_i(os_bits[4]),
		.us_os_ts2_i(os_bits[3]),
		.us_os_hot_reset_i(os_bits[2]),
		.us_os_loopback_i(os_bits[1]),
		.us_os_disable_i(os_bits[0]),
		.us_dl_up_i(dl_up),
		.us_link_l2_i(l2),
		.us_sec_bus_reset_i(us_sbr),
		.ds_sec_bus_reset_i(ds_sbr),
		.ds_transparent_i(2'h1),
		.cfg_mem_present_i(mem),
		.core_reset_o(core_rst),
		.port_cfg_reset_o(cfg_rst),
		.sticky_reset_o(sticky_rst),
		.nonsticky_reset_o(ns_rst),
		.hardware_initialised_field_eval_o(hardware_initialised_field),
		.cfg_load_start_o(cfg_load),
		.us_phy_loopback_o(loop),
		.us_phy_disabled_o(dis),
		.us_tl_dl_up_o(tl_up),
		.us_credit_init_o(us_cred),
		.ds_hot_reset_tx_o(hot_tx),
		.ds_link_down_o(down),
		.ds_drop_requests_o(drop),
		.ds_reg_default_o(regdef),
		.ds_credit_init_o(cred)
	);

	task automatic results();
		if (mismatches == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// sample just after an edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// bounded wait for the core reset to let go
	task automatic wait_release();
		for (int i = 0; i < 20 && core_rst !== 1'b0; i++) begin
			tick(1);
		end
	endtask

	// hang guard, far beyond the roughly 150 cycles the tests take
	initial begin
		repeat (2000) @(posedge clk);
		mismatches++;
		results();
	end

	initial begin
		rst = 1'b1;
		pin_n = 1'b1;
		dl_up = 1'b1;
		l2 = 1'b0;
		mem = 1'b1;
		us_sbr = 1'b0;
		ds_sbr = 2'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wait_release();
		check("release", {hardware_initialised_field, cfg_load, sticky_rst}, 8'h06);
		// two hot sets in a row
		up.send(2, 5'h14);
		tick(3);
		check("hot", {ns_rst, us_cred, cred}, 8'h0f);
		check("hot tx", hot_tx, 8'h01);
		check("kept", {cfg_rst, sticky_rst}, 8'h00);
		tick(6);
		check("hot end", {ns_rst, cfg_load}, 8'h01);
		// no memory fitted: the hot reset must not restart the loader
		@(posedge clk);
		mem <= 1'b0;
		// a plain set between two hot sets breaks the pair; the first
		// plain set clears the count left saturated by the last pair
		up.send(1, 5'h10);
		up.send(1, 5'h14);
		up.send(1, 5'h10);
		up.send(1, 5'h14);
		tick(4);
		check("split", ns_rst, 8'h00);
		// one more hot set completes the pair begun just above
		up.send(1, 5'h14);
		tick(3);
		check("pair", ns_rst, 8'h01);
		tick(6);
		check("no load", {ns_rst, cfg_load}, 8'h00);
		// link drop, then link drop while in L2
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			l2 <= i[0];
			mem <= 1'b1;
			@(posedge clk);
			dl_up <= 1'b0;
			tick(3);
			check("drop", {ns_rst, hot_tx},
				{5'h00, 1'b1, 1'b0, ~i[0]});
			@(posedge clk);
			dl_up <= 1'b1;
			l2 <= 1'b0;
			tick(12);
		end
		// loopback by ts2, left by a plain ts2; disable by ts1
		up.send(2, 5'h0a);
		tick(3);
		check("loopback", {loop, ns_rst}, 8'h03);
		up.send(1, 5'h08);
		tick(3);
		check("loop end", loop, 8'h00);
		up.send(2, 5'h11);
		tick(3);
		check("disabled", dis, 8'h01);
		up.send(1, 5'h10);
		tick(12);
		// upstream bridge bus reset
		@(posedge clk);
		us_sbr <= 1'b1;
		tick(2);
		check("us bus", {down, drop, regdef, hot_tx}, 8'hfd);
		check("us kept", {tl_up, cfg_rst, cfg_load}, 8'h04);
		@(posedge clk);
		us_sbr <= 1'b0;
		tick(3);
		check("us off", {down, drop, regdef, hot_tx}, 8'h00);
		// each downstream bridge bus reset alone
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			ds_sbr <= 2'(1 << i);
			tick(2);
			check("ds bus", {down, drop, cred, regdef},
				{ds_sbr, ds_sbr, ds_sbr, 2'h0});
			check("ds tx", hot_tx, {6'h00, ds_sbr & 2'h1});
			@(posedge clk);
			ds_sbr <= 2'h0;
			tick(3);
		end
		// board reset in mid-run
		@(posedge clk);
		pin_n <= 1'b0;
		tick(4);
		check("board", {core_rst, cfg_rst, sticky_rst}, 8'h07);
		@(posedge clk);
		pin_n <= 1'b1;
		wait_release();
		check("again", {core_rst, hardware_initialised_field, cfg_load}, 8'h03);
		results();
	end
endmodule

`default_nettype wire
